// ===== verilog/rttp_pkg.sv
package rttp_pkg;

    localparam int ID_BYTES = 16;
    localparam int STORE_BYTES = 48;
    localparam int APB_AW = 12;

    // Byte regions inside the receive store.
    localparam logic [5:0] CUR_BASE = 6'h00;
    localparam logic [5:0] RXID_BASE = 6'h10;
    localparam logic [5:0] EXP_BASE = 6'h20;

    // Register byte addresses.
    localparam logic [APB_AW-1:0] CTRL_ADDR = 12'h000;
    localparam logic [APB_AW-1:0] STATUS_ADDR = 12'h004;
    localparam logic [APB_AW-1:0] STORE_ADDR = 12'h100;
    localparam logic [APB_AW-1:0] STORE_END = 12'h1bc;

    // Identifier repetition counts.
    localparam logic [2:0] REPEAT_DECLARE = 3'h5;
    localparam logic [3:0] UNSTABLE_DECLARE = 4'h8;

    // Masks that drop the alignment bit position from a stored byte, or keep every bit.
    localparam logic [7:0] MASK_NORMAL = 8'h7f;
    localparam logic [7:0] MASK_REORDER = 8'hfe;
    localparam logic [7:0] MASK_ALL = 8'hff;

    typedef struct packed {
        logic reorder;
        logic cmp_en;
        logic align_en;
        logic invert;
    } rttp_ctrl_t;

    localparam rttp_ctrl_t CTRL_RESET = 4'h2;

    typedef struct packed {
        logic aligned;
        logic rx_valid;
        logic change;
        logic mismatch;
        logic unstable;
        logic idle;
    } rttp_status_t;

    localparam rttp_status_t STATUS_RESET = 6'h00;
    localparam int STATUS_CHANGE_BIT = 3;

    typedef struct packed {
        logic idle;
        logic los;
        logic lof;
        logic ais;
    } rttp_alarm_t;

    typedef enum logic [1:0] {
        AL_HUNT,
        AL_CONFIRM,
        AL_LOCKED
    } rttp_align_t;

endpackage : rttp_pkg

// ===== verilog/rttp_store.sv
`timescale 1ns/1ps
module rttp_store (
    input wire logic ref_clk, // Clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic ce, // Clock enable.
    input wire logic cur_we, // Current identifier byte write.
    input wire logic [3:0] line_idx, // Line byte position.
    input wire logic [7:0] cur_wdata, // Current identifier byte.
    input wire logic rx_we, // Receive identifier copy write.
    input wire logic [3:0] copy_idx, // Copy byte position.
    input wire logic exp_we, // Expected identifier write.
    input wire logic [3:0] exp_idx, // Expected byte position.
    input wire logic [7:0] exp_wdata, // Expected byte value.
    input wire logic [5:0] bus_idx, // Bus read byte index.
    input wire logic [7:0] cmp_mask, // Bits taking part in comparison.
    output logic [7:0] cur_rd, // Current byte at line position.
    output logic [7:0] rx_rd, // Receive byte at line position.
    output logic [7:0] bus_rd, // Byte at bus index.
    output logic rx_exp_match // Receive equals expected under mask.
);

    logic [7:0] mem [rttp_pkg::STORE_BYTES];
    logic [rttp_pkg::ID_BYTES-1:0] byte_eq;

    // Line side, copy engine and bus write separate regions, so no two ports collide.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < rttp_pkg::STORE_BYTES; i++) begin
                mem[i] <= 8'h00;
            end
        end else if (ce) begin
            if (cur_we) begin
                mem[rttp_pkg::CUR_BASE + {2'h0, line_idx}] <= cur_wdata;
            end
            if (rx_we) begin
                mem[rttp_pkg::RXID_BASE + {2'h0, copy_idx}] <=
                    mem[rttp_pkg::CUR_BASE + {2'h0, copy_idx}];
            end
            if (exp_we) begin
                mem[rttp_pkg::EXP_BASE + {2'h0, exp_idx}] <= exp_wdata;
            end
        end
    end

    assign cur_rd = mem[rttp_pkg::CUR_BASE + {2'h0, line_idx}];
    assign rx_rd = mem[rttp_pkg::RXID_BASE + {2'h0, line_idx}];
    assign bus_rd = (bus_idx < 6'(rttp_pkg::STORE_BYTES)) ? mem[bus_idx] : 8'h00;

    for (genvar k = 0; k < rttp_pkg::ID_BYTES; k++) begin : g_cmp
        assign byte_eq[k] = ((mem[rttp_pkg::RXID_BASE + k] ^ mem[rttp_pkg::EXP_BASE + k])
                             & cmp_mask) == 8'h00;
    end

    assign rx_exp_match = &byte_eq;

endmodule : rttp_store

// ===== verilog/rttp_top.sv
// Function
// - Optional inversion of every incoming trace bit before any processing.
// - Align on a byte whose top bit is one, then fifteen zero top bits.
// - Alignment bit is checked once per completed byte.
// - Alignment can be disabled; bytes then stored from an arbitrary start.
// - Bytes stored in order; alignment-start byte goes to location zero.
// - Same non-zero identifier five times, new: copy to receive, flag change.
// - Idle declared after five all-zero identifiers in a row.
// - Idle ends on stable non-zero identifier or unstable declaration.
// - Unstable after eight identifiers matching neither receive nor previous current.
// - Unstable ends on stable non-zero identifier or idle declaration.
// - Expected comparison uses seven data bits, ignoring the alignment bit.
// - Mismatch follows inequality of receive and expected identifiers.
// - Expected identifier programmable; comparison switchable, off without alignment.
// - Receive identifier invalid after reset; no mismatch until first update.
// - Without reordering first bit lands in bit 7, with reordering bit 0.
// - Store holds 48 bytes: current, receive and expected identifiers.
// - Trace data forced to all ones during loss of signal, frame or AIS.
// - Stream comes from trail trace overhead byte; identifier is 16 bytes.
// - Line writes and register reads of the store are independent.
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
module rttp_top #(
    parameter int ID_LEN = rttp_pkg::ID_BYTES
) (
    input wire logic ref_clk, // 200 MHz clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic ce, // Clock enable, freezes all state when low.
    input wire logic trace_bit, // Serial trace bit from overhead extraction.
    input wire logic trace_bit_valid, // Qualifies trace_bit for one cycle.
    input wire rttp_pkg::rttp_alarm_t alarm, // Line alarm levels.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction.
    input wire logic [rttp_pkg::APB_AW-1:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error.
    output rttp_pkg::rttp_status_t status // Trace status levels.
);

    if (ID_LEN != rttp_pkg::ID_BYTES) begin : g_bad_len
        $error("rttp_top serves only a 16-byte identifier");
    end

    function automatic logic [7:0] rttp_rev(input logic [7:0] b);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = b[7-i];
        end
        return r;
    endfunction : rttp_rev

    rttp_pkg::rttp_ctrl_t ctrl;
    rttp_pkg::rttp_align_t align_state;
    rttp_pkg::rttp_align_t next_align_state;
    logic [6:0] shreg;
    logic [2:0] bit_cnt;
    logic [3:0] pos;
    logic acc_cur;
    logic acc_rx;
    logic acc_nz;
    logic [2:0] reps;
    logic [3:0] mis_cnt;
    logic copy_busy;
    logic [3:0] copy_idx;

    // Line bit conditioning.
    wire any_alarm = alarm.los | alarm.lof | alarm.ais;
    wire inv_bit = trace_bit ^ ctrl.invert;
    wire line_bit = any_alarm ? 1'b1 : inv_bit;
    wire bit_take = ce & trace_bit_valid;
    wire byte_done = bit_take & (bit_cnt == 3'h7);
    wire [7:0] nat_byte = {shreg, line_bit};
    wire [7:0] store_byte = ctrl.reorder ? rttp_rev(nat_byte) : nat_byte;
    wire align_bit = nat_byte[7];
    wire align_on = ctrl.align_en;

    // Byte acceptance and placement.
    wire in_frame = (align_state != rttp_pkg::AL_HUNT) & (pos != 4'h0);
    wire take_byte = byte_done & (~align_on | align_bit | in_frame);
    wire [3:0] wr_pos = (align_on & align_bit) ? 4'h0 : pos;
    wire first_byte = wr_pos == 4'h0;
    wire id_end = take_byte & (wr_pos == 4'(ID_LEN - 1));

    // Masks: data bits only for the zero test when aligned, and for expected compare.
    wire [7:0] data_mask = ctrl.reorder ? rttp_pkg::MASK_REORDER : rttp_pkg::MASK_NORMAL;
    wire [7:0] zero_mask = align_on ? data_mask : rttp_pkg::MASK_ALL;

    wire [7:0] cur_rd;
    wire [7:0] rx_rd;
    wire [7:0] bus_rd;
    wire rx_exp_match;

    // Running identifier comparisons over the bytes of one identifier.
    wire next_acc_cur = (first_byte | acc_cur) & (store_byte == cur_rd);
    wire next_acc_rx = (first_byte | acc_rx) & (store_byte == rx_rd);
    wire next_acc_nz = (~first_byte & acc_nz) | ((store_byte & zero_mask) != 8'h00);
    wire id_same = next_acc_cur;
    wire id_rx = next_acc_rx & status.rx_valid;
    wire id_nz = next_acc_nz;

    // Identifier level decisions.
    wire [2:0] rep_inc = (reps >= rttp_pkg::REPEAT_DECLARE) ? reps : reps + 3'h1;
    wire [2:0] next_reps = id_same ? rep_inc : 3'h1;
    wire repeated = next_reps >= rttp_pkg::REPEAT_DECLARE;
    wire stable_nz = id_end & id_nz & repeated;
    wire idle_set = id_end & ~id_nz & repeated;
    wire do_update = stable_nz & ~id_rx & ~copy_busy;
    wire strange = ~id_same & ~id_rx;
    wire [3:0] mis_inc = (mis_cnt >= rttp_pkg::UNSTABLE_DECLARE) ? mis_cnt : mis_cnt + 4'h1;
    wire [3:0] next_mis = strange ? mis_inc : 4'h0;
    wire unst_set = id_end & (next_mis >= rttp_pkg::UNSTABLE_DECLARE);

    wire next_idle = idle_set ? 1'b1 : ((unst_set | stable_nz) ? 1'b0 : status.idle);
    wire next_unst = unst_set ? 1'b1 : ((idle_set | stable_nz) ? 1'b0 : status.unstable);
    wire cmp_active = ctrl.cmp_en & ctrl.align_en;
    wire next_mismatch = cmp_active & status.rx_valid & ~rx_exp_match;

    // Alignment search.
    always_comb begin
        next_align_state = align_state;
        if (!align_on) begin
            next_align_state = rttp_pkg::AL_HUNT;
        end else if (byte_done) begin
            if (align_bit) begin
                if (align_state == rttp_pkg::AL_LOCKED && pos == 4'h0) begin
                    next_align_state = rttp_pkg::AL_LOCKED;
                end else begin
                    next_align_state = rttp_pkg::AL_CONFIRM;
                end
            end else if (!in_frame) begin
                next_align_state = rttp_pkg::AL_HUNT;
            end else if (pos == 4'(ID_LEN - 1)) begin
                next_align_state = rttp_pkg::AL_LOCKED;
            end
        end
    end

    wire [3:0] next_pos = take_byte ? wr_pos + 4'h1 : ((byte_done & align_on) ? 4'h0 : pos);

    // APB decode.
    wire [rttp_pkg::APB_AW-1:0] store_off = paddr - rttp_pkg::STORE_ADDR;
    wire [5:0] bus_idx = store_off[7:2];
    wire hit_ctrl = paddr == rttp_pkg::CTRL_ADDR;
    wire hit_status = paddr == rttp_pkg::STATUS_ADDR;
    wire hit_store = (paddr >= rttp_pkg::STORE_ADDR) & (paddr <= rttp_pkg::STORE_END)
                     & (paddr[1:0] == 2'h0);
    wire hit_exp = hit_store & (bus_idx >= rttp_pkg::EXP_BASE);
    wire apb_access = psel & penable;
    wire apb_done = ce & apb_access & pready;
    wire bus_wr_ctrl = apb_done & pwrite & hit_ctrl;
    wire bus_wr_status = apb_done & pwrite & hit_status;
    wire exp_we = apb_done & pwrite & hit_exp;
    wire [3:0] exp_idx = 4'(bus_idx - rttp_pkg::EXP_BASE);
    wire change_clr = bus_wr_status & pwdata[rttp_pkg::STATUS_CHANGE_BIT];

    logic [31:0] rd_word;
    logic bad_access;

    always_comb begin
        rd_word = 32'h0000_0000;
        bad_access = 1'b0;
        if (hit_ctrl) begin
            rd_word = {28'h0000000, ctrl};
        end else if (hit_status) begin
            rd_word = {26'h0, status};
        end else if (hit_store) begin
            rd_word = {24'h000000, bus_rd};
            bad_access = pwrite & ~hit_exp;
        end else begin
            bad_access = 1'b1;
        end
    end

    rttp_store u_store (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ce(ce),
        .cur_we(take_byte),
        .line_idx(wr_pos),
        .cur_wdata(store_byte),
        .rx_we(copy_busy),
        .copy_idx(copy_idx),
        .exp_we(exp_we),
        .exp_idx(exp_idx),
        .exp_wdata(pwdata[7:0]),
        .bus_idx(bus_idx),
        .cmp_mask(data_mask),
        .cur_rd(cur_rd),
        .rx_rd(rx_rd),
        .bus_rd(bus_rd),
        .rx_exp_match(rx_exp_match)
    );

    // Bit assembly.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            shreg <= 7'h00;
            bit_cnt <= 3'h0;
        end else if (bit_take) begin
            shreg <= nat_byte[6:0];
            bit_cnt <= bit_cnt + 3'h1;
        end
    end

    // Alignment and byte position.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            align_state <= rttp_pkg::AL_HUNT;
            pos <= 4'h0;
        end else if (ce) begin
            align_state <= next_align_state;
            pos <= next_pos;
        end
    end

    // Per-identifier accumulators.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_cur <= 1'b0;
            acc_rx <= 1'b0;
            acc_nz <= 1'b0;
        end else if (take_byte) begin
            acc_cur <= next_acc_cur;
            acc_rx <= next_acc_rx;
            acc_nz <= next_acc_nz;
        end
    end

    // Repetition counters, updated once per completed identifier.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reps <= 3'h0;
            mis_cnt <= 4'h0;
        end else if (id_end) begin
            reps <= next_reps;
            mis_cnt <= next_mis;
        end
    end

    // Copy of the current identifier into the receive identifier, one byte a cycle.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            copy_busy <= 1'b0;
            copy_idx <= 4'h0;
        end else if (ce) begin
            if (do_update) begin
                copy_busy <= 1'b1;
                copy_idx <= 4'h0;
            end else if (copy_busy) begin
                copy_idx <= copy_idx + 4'h1;
                copy_busy <= copy_idx != 4'(ID_LEN - 1);
            end
        end
    end

    // Status flags.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            status <= rttp_pkg::STATUS_RESET;
        end else if (ce) begin
            status.idle <= next_idle;
            status.unstable <= next_unst;
            status.aligned <= align_on & (next_align_state == rttp_pkg::AL_LOCKED);
            if (copy_busy && copy_idx == 4'(ID_LEN - 1)) begin
                status.rx_valid <= 1'b1;
            end
            if (do_update) begin
                status.change <= 1'b1;
            end else if (change_clr) begin
                status.change <= 1'b0;
            end
            if (!copy_busy) begin
                status.mismatch <= next_mismatch;
            end
        end
    end

    // Control register.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= rttp_pkg::CTRL_RESET;
        end else if (bus_wr_ctrl) begin
            ctrl <= pwdata[3:0];
        end
    end

    // APB answer: one wait state, data and error registered with ready.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= apb_access & ~pready;
            if (apb_access && !pready) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_word;
                pslverr <= bad_access;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

endmodule : rttp_top

// ===== tb/rttp_top_asserts.sv
`timescale 1ns/1ps
module rttp_top_asserts #(
    parameter int ID_LEN = rttp_pkg::ID_BYTES
) (
    input wire logic ref_clk, // Clock.
    input wire logic rst_n, // Reset, active low.
    input wire logic ce, // Enable.
    input wire logic trace_bit, // Trace bit.
    input wire logic trace_bit_valid, // Bit qualifier.
    input wire rttp_pkg::rttp_alarm_t alarm, // Alarms.
    input wire logic psel, // Select.
    input wire logic penable, // Enable.
    input wire logic pwrite, // Direction.
    input wire logic [rttp_pkg::APB_AW-1:0] paddr, // Address.
    input wire logic [31:0] pwdata, // Write data.
    input wire logic [31:0] prdata, // Read data.
    input wire logic pready, // Ready.
    input wire logic pslverr, // Error.
    input wire rttp_pkg::rttp_status_t status // Status.
);
    wire logic in_store = paddr >= rttp_pkg::STORE_ADDR && paddr <= rttp_pkg::STORE_END;
    wire logic mapped = (paddr == rttp_pkg::CTRL_ADDR || paddr == rttp_pkg::STATUS_ADDR
        || in_store) && paddr[1:0] == 2'b00;
    wire logic clear_wr = psel && penable && pready && pwrite
        && paddr == rttp_pkg::STATUS_ADDR && pwdata[rttp_pkg::STATUS_CHANGE_BIT];

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence access_first;
        psel && penable && !pready && ce;
    endsequence
    sequence answer;
        pready ##1 !pready;
    endsequence

    chk_answer_once: assert property (access_first |=> answer)
        else $error("answer not a single cycle after access");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_ro_store: assert property (access_first and pwrite && in_store && paddr < 12'h180
        |=> pslverr)
        else $error("write to read-only store accepted");
    chk_unmapped_err: assert property (access_first and !mapped |=> pslverr)
        else $error("unmapped access accepted");
    chk_read_upper: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
        else $error("read data upper bits set");
    chk_mismatch_valid: assert property (status.mismatch |-> status.rx_valid)
        else $error("mismatch before first update");
    chk_idle_unstable: assert property (!(status.idle && status.unstable))
        else $error("idle and unstable together");
    chk_change_hold: assert property (status.change && !clear_wr |=> status.change)
        else $error("change dropped without clear");
    chk_valid_hold: assert property (status.rx_valid |=> status.rx_valid)
        else $error("receive valid dropped");
    chk_change_copy: assert property ($rose(status.change) |-> ##[0:20] status.rx_valid)
        else $error("change without receive copy");
endmodule : rttp_top_asserts

bind rttp_top rttp_top_asserts #(.ID_LEN(ID_LEN)) i_chk (.ref_clk(ref_clk), .rst_n(rst_n),
    .ce(ce), .trace_bit(trace_bit), .trace_bit_valid(trace_bit_valid), .alarm(alarm),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .status(status));

// ===== tb/rttp_framer_model.sv
`timescale 1ns/1ps
module rttp_framer_model (
    input wire logic ref_clk, // Clock.
    input wire logic start, // Send one identifier.
    input wire logic [127:0] id, // Byte 0 in top bits.
    output logic trace_bit, // Serial bit.
    output logic trace_bit_valid, // Bit qualifier.
    output logic busy // Identifier in flight.
);
    logic [127:0] sh = '0;
    logic [7:0] left = 8'h00;
    initial trace_bit = 1'b0;
    initial trace_bit_valid = 1'b0;
    assign busy = left != 8'h00 || trace_bit_valid;
    // Sixteen overhead bytes leave first bit first; between frames the line wanders.
    always @(posedge ref_clk) begin
        if (left != 8'h00) begin
            trace_bit <= sh[127];
            trace_bit_valid <= 1'b1;
            sh <= {sh[126:0], 1'b0};
            left <= left - 8'h01;
        end else begin
            trace_bit <= ~trace_bit;
            trace_bit_valid <= 1'b0;
            if (start) begin
                sh <= id;
                left <= 8'h80;
            end
        end
    end
endmodule : rttp_framer_model

// ===== tb/rx_trail_trace_processor_test.sv
`timescale 1ns/1ps
module rx_trail_trace_processor_test;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic start = 1'b0;
    logic trace_bit, trace_bit_valid, busy, pready, pslverr, e;
    rttp_pkg::rttp_alarm_t alarm = '0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    rttp_pkg::rttp_status_t status;
    logic [127:0] id_tx = '0, id_a, id_b;
    int fails = 0, checked = 0;

    rttp_top i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .trace_bit(trace_bit),
        .trace_bit_valid(trace_bit_valid), .alarm(alarm), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .status(status));
    rttp_framer_model i_far (.ref_clk(ref_clk), .start(start), .id(id_tx),
        .trace_bit(trace_bit), .trace_bit_valid(trace_bit_valid), .busy(busy));

    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic test_done();
        if (fails == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic [127:0] mk(input logic [7:0] k);
        logic [127:0] v;
        v = '0;
        for (int i = 0; i < 16; i++) begin
            v[127 - 8 * i -: 8] = {i == 0, 7'(k + 8'(i))};
        end
        return v;
    endfunction : mk

    function automatic logic [7:0] bt(input logic [127:0] v, input int i);
        return v[127 - 8 * i -: 8];
    endfunction : bt

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            fails++;
            test_done();
        end
    endtask : apb

    task automatic send(input logic [127:0] id, input int times);
        int n;
        for (int t = 0; t < times; t++) begin
            @(posedge ref_clk);
            id_tx <= id;
            start <= 1'b1;
            @(posedge ref_clk);
            start <= 1'b0;
            n = 0;
            do begin
                @(posedge ref_clk);
                n++;
            end while (busy !== 1'b0 && n < 200);
            if (n >= 200) begin
                fails++;
                test_done();
            end
        end
        repeat (24) @(posedge ref_clk);
    endtask : send

    task automatic sc_reset();
        check("status reset", 32'(status), 32'h0);
        apb(1'b0, rttp_pkg::CTRL_ADDR, 32'h0);
        check("ctrl reset", q, 32'h2);
        apb(1'b0, rttp_pkg::STORE_ADDR + 12'h040, 32'h0);
        check("rx byte reset", q, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        check("unmapped err", 32'(e), 32'h1);
        check("unmapped data", q, 32'h0);
        apb(1'b1, rttp_pkg::STORE_ADDR, 32'h55);
        check("ro store err", 32'(e), 32'h1);
    endtask : sc_reset

    task automatic sc_capture();
        send(id_b, 1);
        send(id_a, 4);
        check("change early", 32'(status.change), 32'h0);
        send(id_a, 1);
        check("change", 32'(status.change), 32'h1);
        check("rx valid", 32'(status.rx_valid), 32'h1);
        for (int i = 0; i < 16; i++) begin
            apb(1'b0, rttp_pkg::STORE_ADDR + 12'(64 + 4 * i), 32'h0);
            check("rx byte", q, 32'(bt(id_a, i)));
        end
        apb(1'b0, rttp_pkg::STORE_ADDR, 32'h0);
        check("cur byte0", q, 32'(bt(id_a, 0)));
        apb(1'b1, rttp_pkg::STATUS_ADDR, 32'h8);
        @(posedge ref_clk);
        check("change clear", 32'(status.change), 32'h0);
    endtask : sc_capture

    task automatic sc_states();
        for (int k = 0; k < 8; k++) begin
            check("unstable early", 32'(status.unstable), 32'h0);
            send(mk(8'(16 + k)), 1);
        end
        check("unstable", 32'(status.unstable), 32'h1);
        send({8'h80, 120'h0}, 4);
        check("idle early", 32'(status.idle), 32'h0);
        send({8'h80, 120'h0}, 1);
        check("idle", 32'(status.idle), 32'h1);
        check("unstable end", 32'(status.unstable), 32'h0);
        send(id_a, 5);
        check("idle end", 32'(status.idle), 32'h0);
        check("same id", 32'(status.change), 32'h0);
        send({8'h80, 120'h0}, 5);
        check("idle again", 32'(status.idle), 32'h1);
        for (int k = 0; k < 8; k++) begin
            send(mk(8'(32 + k)), 1);
        end
        check("idle end unstable", 32'(status.idle), 32'h0);
        check("unstable again", 32'(status.unstable), 32'h1);
        send(id_a, 5);
        check("unstable end stable", 32'(status.unstable), 32'h0);
    endtask : sc_states

    task automatic sc_compare();
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, rttp_pkg::STORE_ADDR + 12'(128 + 4 * i), 32'(bt(id_a, i) ^ 8'h80));
        end
        apb(1'b0, rttp_pkg::STORE_ADDR + 12'h080, 32'h0);
        check("exp byte", q, 32'(bt(id_a, 0) ^ 8'h80));
        apb(1'b1, rttp_pkg::CTRL_ADDR, 32'h6);
        send(id_a, 1);
        check("mask match", 32'(status.mismatch), 32'h0);
        apb(1'b1, rttp_pkg::STORE_ADDR + 12'h084, 32'(bt(id_a, 1) ^ 8'h01));
        send(id_a, 1);
        check("mismatch", 32'(status.mismatch), 32'h1);
        apb(1'b1, rttp_pkg::CTRL_ADDR, 32'h4);
        send(id_a, 1);
        check("cmp forced off", 32'(status.mismatch), 32'h0);
    endtask : sc_compare

    task automatic sc_bits();
        logic [7:0] r;
        logic [7:0] b;
        b = bt(id_a, 1);
        for (int i = 0; i < 8; i++) begin
            r[i] = b[7 - i];
        end
        apb(1'b1, rttp_pkg::CTRL_ADDR, 32'ha);
        send(id_a, 2);
        apb(1'b0, rttp_pkg::STORE_ADDR + 12'h004, 32'h0);
        check("reorder", q, 32'(r));
        apb(1'b1, rttp_pkg::CTRL_ADDR, 32'h3);
        send(~id_a, 2);
        apb(1'b0, rttp_pkg::STORE_ADDR + 12'h004, 32'h0);
        check("invert", q, 32'(bt(id_a, 1)));
        apb(1'b1, rttp_pkg::CTRL_ADDR, 32'h2);
        for (int a = 0; a < 3; a++) begin
            alarm <= rttp_pkg::rttp_alarm_t'(4'(1 << a));
            send(id_a, 1);
            apb(1'b0, rttp_pkg::STORE_ADDR, 32'h0);
            check("alarm ones", q, 32'hff);
            alarm <= '0;
            send(id_a, 1);
        end
    endtask : sc_bits

    task automatic sc_rerun();
        @(posedge ref_clk);
        rst_n <= 1'b0;
        @(posedge ref_clk);
        rst_n <= 1'b1;
        check("status rerun", 32'(status), 32'h0);
        apb(1'b0, rttp_pkg::STORE_ADDR + 12'h040, 32'h0);
        check("rx byte rerun", q, 32'h0);
    endtask : sc_rerun

    initial begin
        id_a = mk(8'h01);
        id_b = mk(8'h40);
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        sc_reset();
        sc_capture();
        sc_states();
        sc_compare();
        sc_bits();
        sc_rerun();
        test_done();
    end
endmodule : rx_trail_trace_processor_test
